/* File: dma_ctl_defines.svh */
// Offsets, field positions and codes of the DMA control block.
// Assumes a 32-bit APB register space with one aligned word per register.
`ifndef DMA_CTL_DEFINES_SVH
`define DMA_CTL_DEFINES_SVH
`define OFS_STATUS   8'h00
`define OFS_CONFIG   8'h04
`define OFS_CTLBASE  8'h08
`define OFS_ALTBASE  8'h0C
`define OFS_ERRCLR   8'h10
`define OFS_CHIS     8'h14
`define OFS_ENASET   8'h18
`define OFS_ENACLR   8'h1C
`define OFS_SWREQ    8'h20
`define OFS_ALTSET   8'h24
`define OFS_ALTCLR   8'h28
`define OFS_IRQMASK  8'h2C
`define BASE_LSB     10
`define BASE_W       22
`define ENTRY_BYTES  16
`define SRC_OFS      32'h0000_0000
`define DST_OFS      32'h0000_0004
`define CTL_OFS      32'h0000_0008
`define MODE_LSB     0
`define MODE_W       3
`define CNT_LSB      4
`define CNT_W        10
`define MODE_STOP    3'h0
`define MODE_BASIC   3'h1
`define MODE_AUTO    3'h2
`define CFG_EN_BIT   0
`endif

/* File: dma_ctl_pkg.sv */
// Types shared by the DMA control block: engine states and memory request.
// Assumes the defines header supplies all numeric constants.
package dma_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FSRC,
    ST_FDST,
    ST_FCTL,
    ST_RD,
    ST_WR,
    ST_WB
  } eng_st_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
endpackage

/* File: dma_ctl.sv */
// DMA global control: master enable, control table base, channel status,
// interrupt routing and a one-item-at-a-time transfer engine.
// Assumes one clock, an APB master, and a memory port that holds mem_ack
// low until an access started by mem_out.req finishes.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "dma_ctl_defines.svh"

// Summary of operation
// - alternate structures in second half, readable
// - fetch control at base; base reads back
// - master enable clear stops all transfers
// - pending error flag drives error interrupt
// - error clear access drops flag and interrupt
// - 32-bit status, one bit per channel
// - writing ones clears matching status bits
// - done interrupt only for software channel
// - peripheral channels signal done on own line
// - table index grows with channels and alternates
// - channel attributes reset cleared
// - completion clears the channel enable
// - completion writes stop mode into control word
module dma_ctl #(
  parameter int NUM_CH = 32,
  parameter int SW_CH  = 31
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_CH-1:0]    periph_req,
  output dma_ctl_pkg::mem_req_t     mem_out,
  input  wire logic [31:0]          mem_rdata,
  input  wire logic                 mem_ack,
  input  wire logic                 mem_err,
  output logic                      dma_done_irq,
  output logic                      dma_error_irq,
  output logic      [NUM_CH-1:0]    periph_done
);
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam logic [31:0] HALF = 32'(NUM_CH * `ENTRY_BYTES);
  typedef struct packed {
    dma_ctl_pkg::eng_st_t  st;
    logic                  master;
    logic [`BASE_W-1:0]    base;
    logic [NUM_CH-1:0]     en;
    logic [NUM_CH-1:0]     alt;
    logic [NUM_CH-1:0]     swp;
    logic [NUM_CH-1:0]     chis;
    logic [NUM_CH-1:0]     mask;
    logic [NUM_CH-1:0]     s1;
    logic [NUM_CH-1:0]     s2;
    logic [NUM_CH-1:0]     s3;
    logic [NUM_CH-1:0]     rq;
    logic                  err;
    logic [CH_W-1:0]       ch;
    logic [31:0]           src;
    logic [31:0]           dst;
    logic [31:0]           ctl;
    logic [31:0]           data;
    logic [`CNT_W-1:0]     cnt;
    logic                  auto_m;
    logic                  fin;
    dma_ctl_pkg::mem_req_t mem;
    logic [31:0]           rdata;
    logic                  rdy;
    logic                  serr;
    logic                  done_irq;
    logic                  err_irq;
    logic [NUM_CH-1:0]     pdone;
  } state_t;
  state_t q_r;
  state_t q_nxt;
  logic              setup;
  logic              wr_acc;
  logic [31:0]       tbl_base;
  logic [31:0]       ent;
  logic [31:0]       cnt_ofs;
  logic              found;
  logic [CH_W-1:0]   sel;
  logic [NUM_CH-1:0] sw_bit;
  // Setup phase prepares the answer; access phase completes with no wait.
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && q_r.rdy;
  assign sw_bit = NUM_CH'(1) << SW_CH;
  // Primary entries start at the base, alternates one half-table later,
  // so the table size scales with the channel count.
  assign tbl_base = {q_r.base, `BASE_LSB'(0)};
  assign ent = tbl_base + (q_r.alt[q_r.ch] ? HALF : 32'h0000_0000)
             + (32'(q_r.ch) << 4);
  assign cnt_ofs = 32'(q_r.cnt) << 2;
  // Single next-state process: bus slave first, engine after, so any
  // hardware set in the same cycle overrides a software clear. The lowest
  // channel with work wins; the master enable gates starts.
  always_comb
  begin
    found = 1'b0;
    sel   = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (!found && q_r.en[i] && (q_r.swp[i] || q_r.rq[i]))
      begin
        found = 1'b1;
        sel   = CH_W'(i);
      end
    end
    q_nxt       = q_r;
    q_nxt.serr  = 1'b0;
    q_nxt.pdone = '0;
    q_nxt.rdy   = setup;
    q_nxt.s1    = periph_req;
    q_nxt.s2    = q_r.s1;
    q_nxt.s3    = q_r.s2;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (q_r.s2[i] == q_r.s3[i])
      begin
        q_nxt.rq[i] = q_r.s3[i];
      end
    end
    q_nxt.rq[SW_CH] = 1'b0;

    // Read data and error answer are latched in the setup cycle.
    if (setup)
    begin
      q_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        `OFS_STATUS:  q_nxt.rdata = {16'h0000, 3'(q_r.st), 3'h0,
                                     5'(q_r.ch), 4'h0, q_r.master};
        `OFS_CONFIG:  q_nxt.rdata = {31'h0, q_r.master};
        `OFS_CTLBASE: q_nxt.rdata = tbl_base;
        `OFS_ALTBASE: q_nxt.rdata = tbl_base + HALF;
        `OFS_ERRCLR:  q_nxt.rdata = {31'h0, q_r.err};
        `OFS_CHIS:    q_nxt.rdata = 32'(q_r.chis);
        `OFS_ENASET, `OFS_ENACLR: q_nxt.rdata = 32'(q_r.en);
        `OFS_SWREQ:   q_nxt.rdata = 32'(q_r.swp);
        `OFS_ALTSET, `OFS_ALTCLR: q_nxt.rdata = 32'(q_r.alt);
        `OFS_IRQMASK: q_nxt.rdata = 32'(q_r.mask);
        default:      q_nxt.serr  = 1'b1;
      endcase
    end

    // Register writes take effect only at the completing access edge.
    if (wr_acc)
    begin
      unique case (paddr)
        `OFS_CONFIG:  q_nxt.master = pwdata[`CFG_EN_BIT];
        `OFS_CTLBASE: q_nxt.base   = pwdata[31:`BASE_LSB];
        `OFS_ERRCLR:  q_nxt.err    = 1'b0;
        `OFS_CHIS:    q_nxt.chis   = q_r.chis &
                                     ~pwdata[NUM_CH-1:0];
        `OFS_ENASET:  q_nxt.en     = q_r.en | pwdata[NUM_CH-1:0];
        `OFS_ENACLR:  q_nxt.en     = q_r.en & ~pwdata[NUM_CH-1:0];
        `OFS_SWREQ:   q_nxt.swp    = q_r.swp |
                                     (pwdata[NUM_CH-1:0] & q_r.en);
        `OFS_ALTSET:  q_nxt.alt    = q_r.alt | pwdata[NUM_CH-1:0];
        `OFS_ALTCLR:  q_nxt.alt    = q_r.alt & ~pwdata[NUM_CH-1:0];
        `OFS_IRQMASK: q_nxt.mask   = pwdata[NUM_CH-1:0];
        default:      q_nxt.master = q_r.master;
      endcase
    end

    // A failed memory access aborts the channel and raises the error.
    if (q_r.mem.req && mem_ack && mem_err)
    begin
      q_nxt.mem.req  = 1'b0;
      q_nxt.err      = 1'b1;
      q_nxt.en[q_r.ch] = 1'b0;
      q_nxt.st       = dma_ctl_pkg::ST_IDLE;
    end
    else
    begin
      unique case (q_r.st)
        dma_ctl_pkg::ST_IDLE:
        begin
          q_nxt.fin = 1'b0;
          if (q_r.master && found)
          begin
            q_nxt.ch       = sel;
            q_nxt.swp[sel] = 1'b0;
            q_nxt.st       = dma_ctl_pkg::ST_FSRC;
          end
        end
        dma_ctl_pkg::ST_FSRC:
        begin
          if (!q_r.mem.req)
          begin
            q_nxt.mem = '{1'b1, 1'b0, ent + `SRC_OFS, 32'h0};
          end
          else if (mem_ack)
          begin
            q_nxt.mem.req = 1'b0;
            q_nxt.src     = mem_rdata;
            q_nxt.st      = dma_ctl_pkg::ST_FDST;
          end
        end
        dma_ctl_pkg::ST_FDST:
        begin
          if (!q_r.mem.req)
          begin
            q_nxt.mem = '{1'b1, 1'b0, ent + `DST_OFS, 32'h0};
          end
          else if (mem_ack)
          begin
            q_nxt.mem.req = 1'b0;
            q_nxt.dst     = mem_rdata;
            q_nxt.st      = dma_ctl_pkg::ST_FCTL;
          end
        end
        dma_ctl_pkg::ST_FCTL:
        begin
          if (!q_r.mem.req)
          begin
            q_nxt.mem = '{1'b1, 1'b0, ent + `CTL_OFS, 32'h0};
          end
          else if (mem_ack)
          begin
            q_nxt.mem.req = 1'b0;
            q_nxt.ctl     = mem_rdata;
            q_nxt.cnt     = mem_rdata[`CNT_LSB +: `CNT_W];
            q_nxt.auto_m  = mem_rdata[`MODE_LSB +: `MODE_W] == `MODE_AUTO;
            // A stopped structure has nothing to move; drop the enable.
            if (mem_rdata[`MODE_LSB +: `MODE_W] == `MODE_STOP)
            begin
              q_nxt.en[q_r.ch] = 1'b0;
              q_nxt.st         = dma_ctl_pkg::ST_IDLE;
            end
            else
            begin
              q_nxt.st = dma_ctl_pkg::ST_RD;
            end
          end
        end
        dma_ctl_pkg::ST_RD:
        begin
          if (!q_r.mem.req)
          begin
            q_nxt.mem = '{1'b1, 1'b0, q_r.src - cnt_ofs, 32'h0};
          end
          else if (mem_ack)
          begin
            q_nxt.mem.req = 1'b0;
            q_nxt.data    = mem_rdata;
            q_nxt.st      = dma_ctl_pkg::ST_WR;
          end
        end
        dma_ctl_pkg::ST_WR:
        begin
          if (!q_r.mem.req)
          begin
            q_nxt.mem = '{1'b1, 1'b1, q_r.dst - cnt_ofs, q_r.data};
          end
          else if (mem_ack)
          begin
            q_nxt.mem.req = 1'b0;
            if (q_r.cnt == '0)
            begin
              q_nxt.fin = 1'b1;
              q_nxt.ctl[`MODE_LSB +: `MODE_W] = `MODE_STOP;
              q_nxt.ctl[`CNT_LSB +: `CNT_W]   = '0;
              q_nxt.st  = dma_ctl_pkg::ST_WB;
            end
            else
            begin
              q_nxt.cnt = q_r.cnt - 1'b1;
              q_nxt.ctl[`CNT_LSB +: `CNT_W] = q_r.cnt - 1'b1;
              // Auto keeps going without requests; basic pauses when the
              // request drops, and both yield when the master is off.
              if (q_r.master && (q_r.auto_m || q_r.rq[q_r.ch]))
              begin
                q_nxt.st = dma_ctl_pkg::ST_RD;
              end
              else
              begin
                q_nxt.st = dma_ctl_pkg::ST_WB;
              end
            end
          end
        end
        dma_ctl_pkg::ST_WB:
        begin
          if (!q_r.mem.req)
          begin
            q_nxt.mem = '{1'b1, 1'b1, ent + `CTL_OFS, q_r.ctl};
          end
          else if (mem_ack)
          begin
            q_nxt.mem.req = 1'b0;
            q_nxt.st      = dma_ctl_pkg::ST_IDLE;
            if (q_r.fin)
            begin
              q_nxt.en[q_r.ch]   = 1'b0;
              q_nxt.chis[q_r.ch] = 1'b1;
              q_nxt.pdone[q_r.ch] = (32'(q_r.ch) != 32'(SW_CH));
            end
          end
        end
      endcase
    end

    // Only the software channel reaches the controller's done line.
    q_nxt.done_irq = |(q_nxt.chis & q_nxt.mask & sw_bit);
    q_nxt.err_irq  = q_nxt.err;
  end
  // All attributes and control state clear on reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end
  assign prdata        = q_r.rdata;
  assign pready        = q_r.rdy;
  assign pslverr       = q_r.serr;  // Only ever set alongside pready.
  assign mem_out       = q_r.mem;
  assign dma_done_irq  = q_r.done_irq;
  assign dma_error_irq = q_r.err_irq;
  assign periph_done   = q_r.pdone;
endmodule

/* File: dma_ctl_sva.sv */
// Checker for the DMA control block: APB timing, memory port, interrupts.
// Assumes it is bound to dma_ctl and sees only that module's ports.
`timescale 1ns/100ps
`include "dma_ctl_defines.svh"
module dma_ctl_sva #(
  parameter int NUM_CH = 32,
  parameter int SW_CH  = 31
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input dma_ctl_pkg::mem_req_t  mem_out,
  input wire logic              mem_ack,
  input wire logic              mem_err,
  input wire logic              dma_done_irq,
  input wire logic              dma_error_irq,
  input wire logic [NUM_CH-1:0] periph_done
);
  // Causes that may legally move an interrupt line; a loose set by intent.
  wire wr_evt = (mem_out.req & mem_ack & mem_out.we) |
                (psel & penable & pwrite);
  wire err_evt = mem_out.req & mem_ack & mem_err;
  wire clr_evt = psel & penable & pready & pwrite & (paddr == `OFS_ERRCLR);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_slverr_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_mem_req_hold: assert property (mem_out.req && !mem_ack |=>
    mem_out.req && $stable(mem_out.addr) && $stable(mem_out.wdata))
    else $error("memory request changed before ack");
  chk_mem_req_drop: assert property (mem_out.req && mem_ack |=> !mem_out.req)
    else $error("memory request not dropped after ack");
  chk_err_irq_cause: assert property ($rose(dma_error_irq) |->
    $past(err_evt) || $past(err_evt, 2))
    else $error("error interrupt without bus error");
  chk_err_irq_clear: assert property (clr_evt && !err_evt |->
    ##[1:2] !dma_error_irq)
    else $error("error interrupt not cleared");
  chk_done_irq_cause: assert property ($rose(dma_done_irq) |->
    $past(wr_evt) || $past(wr_evt, 2))
    else $error("done interrupt without a write");
  chk_sw_no_periph: assert property (!periph_done[SW_CH])
    else $error("software channel used a peripheral done line");
  chk_done_pulse: assert property ((periph_done & $past(periph_done)) == '0)
    else $error("peripheral done longer than one cycle");
endmodule
bind dma_ctl dma_ctl_sva #(.NUM_CH(NUM_CH), .SW_CH(SW_CH))
  dma_ctl_sva_inst (.*);

/* File: dma_mem_model.sv */
// Behavioural system memory on the far side of the DMA memory port.
// Assumes one request at a time, held until the one-cycle ack.
`timescale 1ns/100ps
module dma_mem_model (
  input wire logic             pclk,
  input wire logic             presetn,
  input dma_ctl_pkg::mem_req_t mem_out,
  input wire logic             err_on,
  output logic [31:0]          mem_rdata,
  output logic                 mem_ack,
  output logic                 mem_err
);
  logic [31:0] mem [0:1023];
  int          cnt;
  logic        slow;
  // Alternates prompt and slow answers; the idle data bus toggles so a
  // stale value can never pass for read data.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= 32'h0;
      cnt <= 0;
      slow <= 1'b0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_out.req && !mem_ack && cnt >= (slow ? 3 : 0))
      begin
        mem_ack <= 1'b1;
        mem_err <= err_on;
        cnt <= 0;
        slow <= !slow;
        mem_rdata <= mem[mem_out.addr[11:2]];
        if (mem_out.we && !err_on)
          mem[mem_out.addr[11:2]] <= mem_out.wdata;
      end
      else if (mem_out.req && !mem_ack)
        cnt <= cnt + 1;
    end
endmodule

/* File: dma_control_table_and_interrupts_tb.sv */
// Testbench: register-level tests of the DMA control block over APB.
// Assumes dma_ctl, its checker and the memory model are compiled first.
`timescale 1ns/100ps
`include "dma_ctl_defines.svh"
module dma_control_table_and_interrupts_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, err_on = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, periph_req = 32'h0, prdata, mem_rdata, q;
  logic [31:0] periph_done;
  logic pready, pslverr, mem_ack, mem_err, dma_done_irq, dma_error_irq, e;
  dma_ctl_pkg::mem_req_t mem_out;
  int fails = 0, comparisons = 0, k;
  dma_ctl dma_ctl_inst (.*);
  dma_mem_model dma_mem_model_inst (.*);
  // Half period of 2 ns gives the 250 MHz clock.
  always #2 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // Waits for done (0), error (1) or channel 0 done (2); a hang is left
  // to the watchdog, which counts it as a mismatch.
  task automatic wt(input int s);
    do
      @(posedge pclk);
    while ((s == 0 ? dma_done_irq : s == 1 ? dma_error_irq
           : periph_done[0]) !== 1'b1);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Table at 0x400: channel 31 copies four words, channel 0 one word.
  initial
  begin
    for (k = 0; k < 1024; k++)
      dma_mem_model_inst.mem[k] = 32'h0;
    for (k = 0; k < 4; k++)
      dma_mem_model_inst.mem[12'h200 + k] = 32'hA0 + 32'(k);
    dma_mem_model_inst.mem[12'h17C] = 32'h80C;
    dma_mem_model_inst.mem[12'h17D] = 32'h90C;
    dma_mem_model_inst.mem[12'h17E] = 32'h32;
    dma_mem_model_inst.mem[12'h100] = 32'h810;
    dma_mem_model_inst.mem[12'h101] = 32'h950;
    dma_mem_model_inst.mem[12'h102] = 32'h1;
    dma_mem_model_inst.mem[12'h204] = 32'h55;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_CONFIG, 32'h0);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_ENASET, 32'h0);
    rd(`OFS_CHIS, 32'h0);
    apb(1'b1, `OFS_CTLBASE, 32'h400);
    rd(`OFS_CTLBASE, 32'h400);
    rd(`OFS_ALTBASE, 32'h600);
    rd(8'h40, 32'h0);
    chk(e, 32'h1);
    apb(1'b1, `OFS_IRQMASK, 32'hFFFF_FFFF);
    apb(1'b1, `OFS_ENASET, 32'h8000_0000);
    apb(1'b1, `OFS_SWREQ, 32'h8000_0000);
    repeat (40) @(posedge pclk);
    chk(dma_mem_model_inst.mem[12'h240], 32'h0);
    chk(dma_done_irq, 32'h0);
    // The request left pending while disabled now starts the copy.
    apb(1'b1, `OFS_CONFIG, 32'h1);
    wt(0);
    for (k = 0; k < 4; k++)
      chk(dma_mem_model_inst.mem[12'h240 + k], 32'hA0 + 32'(k));
    chk(dma_done_irq, 32'h1);
    chk(dma_mem_model_inst.mem[12'h17E] & 32'h7, `MODE_STOP);
    rd(`OFS_ENASET, 32'h0);
    rd(`OFS_CHIS, 32'h8000_0000);
    apb(1'b1, `OFS_CHIS, 32'h7FFF_FFFF);
    rd(`OFS_CHIS, 32'h8000_0000);
    apb(1'b1, `OFS_CHIS, 32'h8000_0000);
    rd(`OFS_CHIS, 32'h0);
    chk(dma_done_irq, 32'h0);
    periph_req <= 32'h1;
    apb(1'b1, `OFS_ENASET, 32'h1);
    wt(2);
    periph_req <= 32'h0;
    chk(dma_mem_model_inst.mem[12'h254], 32'h55);
    rd(`OFS_CHIS, 32'h1);
    chk(dma_done_irq, 32'h0);
    // Alternate half: one auto item from 0x80C to 0x980; the primary
    // entry is in stop mode, so only the alternate can finish.
    dma_mem_model_inst.mem[12'h1FC] = 32'h80C;
    dma_mem_model_inst.mem[12'h1FD] = 32'h980;
    dma_mem_model_inst.mem[12'h1FE] = 32'h2;
    apb(1'b1, `OFS_ALTSET, 32'h8000_0000);
    rd(`OFS_ALTSET, 32'h8000_0000);
    apb(1'b1, `OFS_ENASET, 32'h8000_0000);
    apb(1'b1, `OFS_SWREQ, 32'h8000_0000);
    wt(0);
    chk(dma_mem_model_inst.mem[12'h260], 32'hA3);
    chk(dma_mem_model_inst.mem[12'h1FE] & 32'h7, `MODE_STOP);
    apb(1'b1, `OFS_CHIS, 32'h8000_0001);
    apb(1'b1, `OFS_ALTCLR, 32'h8000_0000);
    rd(`OFS_ALTSET, 32'h0);
    // Enable alone must not start the software channel.
    err_on <= 1'b1;
    dma_mem_model_inst.mem[12'h17E] = 32'h32;
    apb(1'b1, `OFS_ENASET, 32'h8000_0000);
    repeat (20) @(posedge pclk);
    chk(dma_error_irq, 32'h0);
    apb(1'b1, `OFS_SWREQ, 32'h8000_0000);
    wt(1);
    rd(`OFS_ERRCLR, 32'h1);
    err_on <= 1'b0;
    apb(1'b1, `OFS_ERRCLR, 32'h0);
    rd(`OFS_ERRCLR, 32'h0);
    chk(dma_error_irq, 32'h0);
    stop_test;
  end
  // A hang counts as a mismatch; the whole run needs a few hundred cycles.
  initial
  begin
    #200000;
    fails++;
    stop_test;
  end
endmodule
